// ### nfctw_target_top.sv
// Target-side wake-up, first-command classification and status.
// Assumes RF front-end signals synchronous to pclk, an always-on
// reset separate from the main digital reset, and an APB master.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
module nfctw_target_top import nfctw_pkg::*; #(
	parameter int BIT_CYC = BIT_PERIOD_CYC,
	parameter int UNIT_CYC = NORESP_UNIT_CYC
) (
	// Clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic aon_por_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power pins
	input wire logic power_up_pin,
	input wire logic supply_keep_pin,
	output logic forced_power_up,
	output logic supply_on,
	// RF front end
	input wire logic [10:0] rf_level_mv,
	input wire logic osc_stable,
	input wire logic first_cmd_valid,
	input wire nfctw_first_cmd_t first_cmd,
	input wire nfctw_evt_t evt,
	// Target control outputs
	output logic irq,
	output nfctw_mode_t target_mode,
	output logic clock_extractor_en,
	output logic fifo_cmd_write,
	output logic sdd_auto_start,
	output logic [1:0] sdd_id_size
);

	// ==========================================================
	// Register storage
	logic [7:0] pc_ff, nrw_ff, sf_ff, lf_ff, wt_ff, irq_st_ff, rdata_ff;
	logic [4:0] tp_info_ff;
	logic irq_ff, osc_ok_ff, wake_cmp_ff, coll_cmp_ff, rx_busy_ff, err_ff;
	nfctw_wake_t wake_ff;
	nfctw_wake_t nxt_wake;
	nfctw_mode_t mode_ff;

	// ==========================================================
	// APB decode
	logic setup, access, wr_en, rd_done, mapped;
	logic [4:0] idx;
	logic [7:0] tp_read, rd_mux;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wr_en = access && pwrite && pstrb[0];
	assign rd_done = access && !pwrite;
	assign idx = paddr[6:2];
	assign pready = 1'b1;
	assign pslverr = access && err_ff;
	assign prdata = {24'h000000, rdata_ff};

	// Address decode; high bit and byte offset must be zero
	assign mapped = !paddr[7] && (paddr[1:0] == 2'h0) && (idx inside {
		IDX_PROTO_CTRL, IDX_NORESP_WAIT, IDX_IRQ_STATUS, IDX_OSC_STATUS,
		IDX_SPECIAL_FN, IDX_LOW_FIELD, IDX_WAKE_THRESH, IDX_TARGET_INFO});

	// Live comparators beside the latched first-command fields
	assign tp_read = {wake_cmp_ff, coll_cmp_ff, 1'b0, tp_info_ff}; // RL4 RL5

	// Read mux
	always_comb begin
		case (idx)
			IDX_PROTO_CTRL: rd_mux = pc_ff;
			IDX_NORESP_WAIT: rd_mux = nrw_ff;
			IDX_IRQ_STATUS: rd_mux = irq_st_ff;
			IDX_OSC_STATUS: rd_mux = {1'b0, osc_ok_ff, 6'h00};
			IDX_SPECIAL_FN: rd_mux = sf_ff;
			IDX_LOW_FIELD: rd_mux = lf_ff;
			IDX_WAKE_THRESH: rd_mux = wt_ff;
			IDX_TARGET_INFO: rd_mux = tp_read;
			default: rd_mux = 8'h00;
		endcase
		if (!mapped) begin
			rd_mux = 8'h00;
		end
	end

	// Read data and error captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_ff <= 8'h00;
			err_ff <= 1'b0;
		end else if (setup) begin
			rdata_ff <= pwrite ? 8'h00 : rd_mux;
			err_ff <= !mapped;
		end
	end

	// ==========================================================
	// Configuration registers on the main reset
	logic wr_pc;

	assign wr_pc = wr_en && mapped && (idx == IDX_PROTO_CTRL);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_ff <= PC_RST;
			nrw_ff <= NRW_RST;
			sf_ff <= SF_RST;
			lf_ff <= LF_RST;
		end else if (wr_en && mapped) begin
			case (idx)
				IDX_PROTO_CTRL: pc_ff <= pwdata[7:0];
				IDX_NORESP_WAIT: nrw_ff <= pwdata[7:0];
				IDX_SPECIAL_FN: sf_ff <= pwdata[7:0];
				IDX_LOW_FIELD: lf_ff <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// Threshold register lives on the always-on reset only
	always_ff @(posedge pclk or negedge aon_por_n) begin
		if (!aon_por_n) begin
			wt_ff <= WT_RST; // RL2
		end else if (wr_en && mapped && idx == IDX_WAKE_THRESH) begin
			wt_ff <= pwdata[7:0] & WT_WRITE_MASK;
		end
	end

	assign sdd_id_size = wt_ff[WT_ID_LSB +: 2];

	// ==========================================================
	// Field comparators and oscillator flag
	logic [10:0] wake_thr;
	logic [10:0] coll_thr;

	assign wake_thr = thr_mv(wt_ff[WT_RANGE_BIT], wt_ff[2:0]); // RL1
	assign coll_thr = thr_mv(1'b0, lf_ff[2:0]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cmp_ff <= 1'b0;
			coll_cmp_ff <= 1'b0;
			osc_ok_ff <= 1'b0;
		end else begin
			// Code zero switches the detector off
			wake_cmp_ff <= (wt_ff[2:0] != 3'h0) &&
				(rf_level_mv > wake_thr); // RL1 RL4
			coll_cmp_ff <= (lf_ff[2:0] != 3'h0) &&
				(rf_level_mv > coll_thr); // RL5
			osc_ok_ff <= osc_stable; // RL3
		end
	end

	// ==========================================================
	// Wake-up sequence
	logic field_lost, fc_event, enable_n;

	assign forced_power_up = (wake_ff == WK_OSC) ||
		(wake_ff == WK_CMD); // RL23
	assign enable_n = !(power_up_pin || forced_power_up);
	assign supply_on = supply_keep_pin || !enable_n;
	assign field_lost = (wake_ff != WK_OFF) && !wake_cmp_ff;

	// Next state; forced power-up ends with the receive interrupt
	always_comb begin
		nxt_wake = wake_ff;
		fc_event = 1'b0;
		case (wake_ff)
			WK_OFF: begin
				if (wake_cmp_ff) begin
					nxt_wake = WK_OSC; // RL23
				end
			end
			WK_OSC: begin
				if (osc_stable) begin
					nxt_wake = WK_CMD;
					fc_event = 1'b1; // RL3
				end
			end
			WK_CMD: begin
				if (evt.rx_done) begin
					nxt_wake = WK_RUN; // RL6 RL7
				end
			end
			WK_RUN: begin
				if (!power_up_pin) begin
					nxt_wake = WK_OFF;
				end
			end
			default: begin
				nxt_wake = WK_OFF;
			end
		endcase
		if (field_lost) begin
			nxt_wake = WK_OFF;
			fc_event = 1'b1; // RL13
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_ff <= WK_OFF;
		end else begin
			wake_ff <= nxt_wake;
		end
	end

	// ==========================================================
	// First-command classification and target mode
	logic take_cmd, is_req, card_emu;
	nfctw_mode_t cmd_mode;

	assign take_cmd = first_cmd_valid && (wake_ff == WK_CMD); // RL8
	assign is_req = (first_cmd.kind == CMD_SENS_ALL);
	assign card_emu = pc_ff[PC_CARD_EMU_BIT];

	// Mode chosen by the first command
	always_comb begin
		case (first_cmd.kind)
			CMD_SENS_ALL: begin
				cmd_mode = card_emu ? MODE_CARD_A : MODE_PASSIVE_TARGET_SLOW_FLAG; // RL12 RL15
			end
			CMD_SENSF: begin
				cmd_mode = MODE_PAS_F; // RL16
			end
			CMD_ATR: begin
				cmd_mode = MODE_ACTIVE; // RL17
			end
			default: begin
				cmd_mode = MODE_IDLE;
			end
		endcase
		if (first_cmd.coding == CODE_B) begin
			cmd_mode = card_emu ? MODE_CARD_B : MODE_IDLE; // RL18
		end
	end

	// Latched protocol fields; read clears only the bits read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tp_info_ff <= TP_RST;
		end else if (enable_n) begin
			tp_info_ff <= TP_RST; // RL11
		end else if (take_cmd) begin
			tp_info_ff <= {first_cmd.coding == CODE_F, is_req,
				first_cmd.coding == CODE_B, first_cmd.rate}; // RL9 RL10
		end else if (rd_done && mapped && idx == IDX_TARGET_INFO) begin
			tp_info_ff <= tp_info_ff & ~rdata_ff[4:0]; // RL11
		end
	end

	// Mode register; aborted on field loss or disable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= MODE_IDLE;
		end else if (enable_n || nxt_wake == WK_OFF) begin
			mode_ff <= MODE_IDLE; // RL13
		end else if (take_cmd) begin
			mode_ff <= cmd_mode;
		end
	end

	assign target_mode = mode_ff;
	assign clock_extractor_en = (mode_ff == MODE_PASSIVE_TARGET_SLOW_FLAG) ||
		(mode_ff == MODE_CARD_A); // RL14

	// Hand the request to the FIFO or to automatic detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_cmd_write <= 1'b0;
			sdd_auto_start <= 1'b0;
		end else begin
			fifo_cmd_write <= take_cmd && is_req &&
				!wt_ff[WT_SDD_BIT]; // RL12
			sdd_auto_start <= take_cmd && is_req &&
				wt_ff[WT_SDD_BIT]; // RL24
		end
	end

	// ==========================================================
	// Collision and no-response detectors
	logic coll_pulse, noresp_pulse;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_busy_ff <= 1'b0;
		end else if (evt.rx_sof) begin
			rx_busy_ff <= 1'b1;
		end else if (evt.rx_done) begin
			rx_busy_ff <= 1'b0;
		end
	end

	nfctw_coll_detect #(
		.BIT_CYC(BIT_CYC)
	) u_coll (
		.pclk(pclk),
		.presetn(presetn),
		.active(rx_busy_ff),
		.limit_sel7(sf_ff[SF_COLL7_BIT]),
		.rf_edge(evt.rf_edge),
		.coll_pulse(coll_pulse)
	);

	nfctw_noresp_timer #(
		.UNIT_CYC(UNIT_CYC)
	) u_noresp (
		.pclk(pclk),
		.presetn(presetn),
		.start(evt.tx_done && pc_ff[PC_VICINITY_BIT]), // RL22
		.stop(evt.rx_sof),
		.wait_units(nrw_ff),
		.expire(noresp_pulse)
	);

	// ==========================================================
	// Interrupt cause status and request line
	logic [7:0] st_set, st_clr_rd;
	logic st_clr_all, irq_now, irq_end;

	// Event sets per bit
	always_comb begin
		st_set = 8'h00;
		st_set[IRQ_TX_BIT] = evt.tx_start; // RL20
		st_set[IRQ_RX_BIT] = evt.rx_sof; // RL20 RL6
		st_set[IRQ_FIFO_BIT] = evt.fifo_level; // RL21
		st_set[IRQ_CRC_BIT] = evt.crc_err &&
			!pc_ff[PC_NO_RX_CRC_BIT]; // RL21
		st_set[IRQ_PAR_BIT] = evt.parity_err; // RL21
		st_set[IRQ_FRM_BIT] = evt.framing_err || fc_event; // RL21 RL3
		st_set[IRQ_COL_BIT] = coll_pulse; // RL22
		st_set[IRQ_NORESP_BIT] = noresp_pulse; // RL22
	end

	assign st_clr_all = enable_n || wr_pc; // RL19
	assign st_clr_rd = (rd_done && mapped && idx == IDX_IRQ_STATUS) ?
		rdata_ff : 8'h00;
	// Transfer flags raise the request only at completion
	assign irq_end = (evt.tx_done &&
		(irq_st_ff[IRQ_TX_BIT] || evt.tx_start)) ||
		(evt.rx_done && (irq_st_ff[IRQ_RX_BIT] || evt.rx_sof)); // RL20
	assign irq_now = irq_end || (|st_set[5:0]);

	// Set wins over any clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_ff <= IRQ_RST;
			irq_ff <= 1'b0;
		end else begin
			if (st_clr_all) begin
				irq_st_ff <= st_set; // RL19
			end else begin
				irq_st_ff <= (irq_st_ff & ~st_clr_rd) | st_set; // RL19
			end
			if (irq_now) begin
				irq_ff <= 1'b1;
			end else if (st_clr_all || st_clr_rd != 8'h00) begin
				irq_ff <= 1'b0; // RL19
			end
		end
	end
	assign irq = irq_ff;
endmodule

// ### nfctw_pkg.sv
// Shared constants, register map and types of the NFC target
// wake-up and first-command detection block.
// Assumes a 100 MHz pclk and word-aligned APB register access.
// Function
// (RL1) Decode three-bit threshold code with range bit
// (RL2) Threshold register cleared only by always-on reset
// (RL3) Oscillator ready sets osc flag, field-change event
// (RL4) Bit 7 shows wake-up comparator always
// (RL5) Bit 6 shows collision comparator always
// (RL6) First command raises receive-start interrupt
// (RL7) Host confirms power-up between both interrupts
// (RL8) Latch first command protocol once received
// (RL9) Report type-F, request and type-B flags
// (RL10) Report first command bit rate code
// (RL11) Protocol info clears on disable, read
// (RL12) Request enters slow passive, FIFO if manual
// (RL13) Field loss raises field-change, aborts procedure
// (RL14) Clock extractor on for slow passive modes
// (RL15) Card emulation bit selects type-A card
// (RL16) Type-F request gives fast passive target
// (RL17) Attribute request gives active target mode
// (RL18) Type-B with emulation enters type-B card
// (RL19) Status clears on disable, control write, read
// (RL20) Transfer flags set early, request at end
// (RL21) FIFO, CRC, parity and framing status flags
// (RL22) Collision edge count and no-response timeout
// (RL23) Field above threshold forces internal power-up
// (RL24) Automatic detection uses internal state machine
package nfctw_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int BIT_PERIOD_NS = 9440;
	localparam int BIT_PERIOD_CYC = BIT_PERIOD_NS / CLK_PERIOD_NS;
	localparam int NORESP_UNIT_NS = 1000;
	localparam int NORESP_UNIT_CYC = NORESP_UNIT_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [4:0] IDX_PROTO_CTRL = 5'h01;
	localparam logic [4:0] IDX_NORESP_WAIT = 5'h07;
	localparam logic [4:0] IDX_IRQ_STATUS = 5'h0c;
	localparam logic [4:0] IDX_OSC_STATUS = 5'h0f;
	localparam logic [4:0] IDX_SPECIAL_FN = 5'h10;
	localparam logic [4:0] IDX_LOW_FIELD = 5'h16;
	localparam logic [4:0] IDX_WAKE_THRESH = 5'h18;
	localparam logic [4:0] IDX_TARGET_INFO = 5'h19;

	// ==========================================================
	// Reset values
	localparam logic [7:0] PC_RST = 8'h00;
	localparam logic [7:0] NRW_RST = 8'h0e;
	localparam logic [7:0] SF_RST = 8'h00;
	localparam logic [7:0] LF_RST = 8'h00;
	localparam logic [7:0] WT_RST = 8'h00;
	localparam logic [7:0] IRQ_RST = 8'h00;
	localparam logic [4:0] TP_RST = 5'h00;

	// ==========================================================
	// Field positions
	localparam int TP_WAKE_BIT = 7;
	localparam int TP_COLL_BIT = 6;
	localparam int TP_TYPEF_BIT = 4;
	localparam int TP_PASSIVE_TARGET_SLOW_FLAG_BIT = 3;
	localparam int TP_TYPEB_BIT = 2;
	localparam int IRQ_TX_BIT = 7;
	localparam int IRQ_RX_BIT = 6;
	localparam int IRQ_FIFO_BIT = 5;
	localparam int IRQ_CRC_BIT = 4;
	localparam int IRQ_PAR_BIT = 3;
	localparam int IRQ_FRM_BIT = 2;
	localparam int IRQ_COL_BIT = 1;
	localparam int IRQ_NORESP_BIT = 0;
	localparam int WT_RANGE_BIT = 3;
	localparam int WT_SDD_BIT = 5;
	localparam int WT_ID_LSB = 6;
	localparam logic [7:0] WT_WRITE_MASK = 8'hef;
	localparam int PC_NO_RX_CRC_BIT = 7;
	localparam int PC_VICINITY_BIT = 3;
	localparam int PC_CARD_EMU_BIT = 2;
	localparam int OSC_OK_BIT = 6;
	localparam int SF_COLL7_BIT = 0;

	// ==========================================================
	// Codes
	localparam logic [1:0] RATE_106 = 2'h1;
	localparam logic [1:0] RATE_212 = 2'h2;
	localparam logic [1:0] RATE_424 = 2'h3;
	localparam logic [3:0] COLL_LIMIT_6 = 4'h6;
	localparam logic [3:0] COLL_LIMIT_7 = 4'h7;
	// Threshold in mV per code 7..0; code 0 is off
	localparam logic [7:0][10:0] THR_LO_MV = {11'h0aa, 11'h0b4,
		11'h0be, 11'h0dc, 11'h0fa, 11'h15e, 11'h1e0, 11'h000};
	localparam logic [7:0][10:0] THR_HI_MV = {11'h118, 11'h140,
		11'h190, 11'h1c2, 11'h1f4, 11'h2bc, 11'h5dc, 11'h000};

	// ==========================================================
	// Types
	typedef enum logic [1:0] {CMD_OTHER, CMD_SENS_ALL, CMD_SENSF,
		CMD_ATR} nfctw_cmd_kind_t;
	typedef enum logic [1:0] {CODE_A, CODE_F, CODE_B} nfctw_coding_t;
	typedef struct packed {
		nfctw_cmd_kind_t kind;
		nfctw_coding_t coding;
		logic [1:0] rate;
	} nfctw_first_cmd_t;
	typedef struct packed {
		logic tx_start;
		logic tx_done;
		logic rx_sof;
		logic rx_done;
		logic fifo_level;
		logic crc_err;
		logic parity_err;
		logic framing_err;
		logic rf_edge;
	} nfctw_evt_t;
	typedef enum logic [2:0] {MODE_IDLE, MODE_PASSIVE_TARGET_SLOW_FLAG, MODE_CARD_A,
		MODE_PAS_F, MODE_ACTIVE, MODE_CARD_B} nfctw_mode_t;
	typedef enum logic [1:0] {WK_OFF, WK_OSC, WK_CMD,
		WK_RUN} nfctw_wake_t;

	// Threshold in mV for a code; code 0 gives 0 (detector off)
	function automatic logic [10:0] thr_mv(logic hi, logic [2:0] code);
		return hi ? THR_HI_MV[code] : THR_LO_MV[code];
	endfunction

endpackage

// ### nfctw_coll_detect.sv
// Counts field edges inside each slow-rate bit period.
// Assumes rf_edge is a one-cycle pulse synchronous to pclk.
`timescale 1ns/100ps
module nfctw_coll_detect import nfctw_pkg::*; #(
	parameter int BIT_CYC = BIT_PERIOD_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic active,
	input wire logic limit_sel7,
	input wire logic rf_edge,
	// Result
	output logic coll_pulse
);
	localparam int CW = $clog2(BIT_CYC);
	logic [CW-1:0] per_ff;
	logic [3:0] edges_ff;
	logic [3:0] limit;
	logic per_end;

	assign limit = limit_sel7 ? COLL_LIMIT_7 : COLL_LIMIT_6;
	assign per_end = (per_ff == CW'(BIT_CYC - 1));

	// Bit period counter and saturating edge count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_ff <= '0;
			edges_ff <= 4'h0;
			coll_pulse <= 1'b0;
		end else begin
			coll_pulse <= 1'b0;
			if (!active || per_end) begin
				per_ff <= '0;
				edges_ff <= 4'h0;
				coll_pulse <= active && (edges_ff > limit); // RL22
			end else begin
				per_ff <= per_ff + 1'b1;
				if (rf_edge && edges_ff != 4'hf) begin
					edges_ff <= edges_ff + 1'b1;
				end
			end
		end
	end
endmodule

// ### nfctw_noresp_timer.sv
// No-response timer: counts the programmed wait after transmit.
// Assumes start and stop are one-cycle pulses on pclk.
`timescale 1ns/100ps
module nfctw_noresp_timer import nfctw_pkg::*; #(
	parameter int UNIT_CYC = NORESP_UNIT_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic start,
	input wire logic stop,
	input wire logic [7:0] wait_units,
	// Result
	output logic expire
);
	localparam int DW = $clog2(UNIT_CYC);
	logic [DW-1:0] div_ff;
	logic [7:0] cnt_ff;
	logic run_ff;
	logic tick;

	assign tick = run_ff && (div_ff == DW'(UNIT_CYC - 1));

	// Unit divider gives a one-cycle enable while running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= '0;
		end else if (start || !run_ff || tick) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	// Wait counter; a reply start stops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_ff <= 1'b0;
			cnt_ff <= 8'h00;
			expire <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (start) begin
				run_ff <= 1'b1;
				cnt_ff <= wait_units;
			end else if (stop) begin
				run_ff <= 1'b0;
			end else if (tick) begin
				if (cnt_ff <= 8'h01) begin
					run_ff <= 1'b0;
					expire <= 1'b1; // RL22
				end else begin
					cnt_ff <= cnt_ff - 1'b1;
				end
			end
		end
	end
endmodule

// ### nfctw_monitor.sv
// Port checker of the target top, bound into every instance.
// Assumes one pclk domain with presetn as its reset.
`timescale 1ns/100ps
module nfctw_monitor import nfctw_pkg::*; (
	// Clock and resets
	input wire logic pclk,
	input wire logic presetn,
	input wire logic aon_por_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Power and RF
	input wire logic power_up_pin,
	input wire logic supply_keep_pin,
	input wire logic forced_power_up,
	input wire logic supply_on,
	input wire logic [10:0] rf_level_mv,
	input wire logic osc_stable,
	input wire logic first_cmd_valid,
	input wire nfctw_first_cmd_t first_cmd,
	input wire nfctw_evt_t evt,
	// Target outputs
	input wire logic irq,
	input wire nfctw_mode_t target_mode,
	input wire logic clock_extractor_en,
	input wire logic fifo_cmd_write,
	input wire logic sdd_auto_start,
	input wire logic [1:0] sdd_id_size
);
	// ==========================================================
	// Sequences
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_wr_thr;
		psel && penable && pwrite && pstrb[0] && paddr == 8'h60;
	endsequence
	sequence s_rd_stat;
		psel && penable && !pwrite && paddr == 8'h30;
	endsequence
	sequence s_rx_frame;
		evt.rx_sof ##1 !psel ##1 evt.rx_done && forced_power_up;
	endsequence
	// ==========================================================
	// Assertions
	a_thr_id_size: assert property (s_wr_thr ##1 aon_por_n
		|-> sdd_id_size == $past(pwdata[7:6]))
		else $error("id size not taken from threshold write");
	a_fifo_cause: assert property (fifo_cmd_write
		|-> $past(first_cmd_valid) && $past(first_cmd.kind) == CMD_SENS_ALL)
		else $error("fifo write without request command");
	a_sdd_cause: assert property (sdd_auto_start
		|-> $past(first_cmd_valid)) else $error("sdd start without command");
	a_mode_cause: assert property (target_mode != MODE_IDLE &&
		$past(target_mode) == MODE_IDLE |-> $past(first_cmd_valid))
		else $error("mode left idle without first command");
	a_extractor_mode: assert property (clock_extractor_en ==
		(target_mode inside {MODE_PASSIVE_TARGET_SLOW_FLAG, MODE_CARD_A}))
		else $error("clock extractor does not follow mode");
	a_supply_on: assert property (supply_on ==
		(supply_keep_pin || power_up_pin || forced_power_up))
		else $error("supply enable wrong");
	a_slverr_access: assert property (pslverr
		|-> psel && penable && (pwrite || prdata == 32'h0))
		else $error("error response outside access");
	a_stat_read_clr: assert property (s_rd_stat ##0 (evt == '0 &&
		!first_cmd_valid && $stable(osc_stable) && $stable(rf_level_mv))
		|=> !irq) else $error("irq survives status read");
	a_rx_done_irq: assert property (s_rx_frame |=> irq)
		else $error("no irq at receive end");
	a_tx_start_quiet: assert property (evt == 9'h100 && !irq &&
		$stable(rf_level_mv) && $stable(osc_stable) |=> !irq)
		else $error("irq raised at transmit start");
endmodule

bind nfctw_target_top nfctw_monitor i_mon (.*);

// ### nfctw_rf_peer.sv
// Behavioural RF initiator: field, oscillator and first frame.
// Assumes every task is entered just after a pclk rising edge.
`timescale 1ns/100ps
module nfctw_rf_peer import nfctw_pkg::*; (
	// Clock
	input wire logic pclk,
	// RF front end
	output logic [10:0] rf_level_mv,
	output logic osc_stable,
	output logic first_cmd_valid,
	output nfctw_first_cmd_t first_cmd,
	output nfctw_evt_t evt
);
	// ==========================================================
	// Quiet front end
	initial begin
		rf_level_mv = 11'h000;
		osc_stable = 1'h0;
		first_cmd_valid = 1'h0;
		first_cmd = '0;
		evt = '0;
	end
	// Field level and oscillator state
	task automatic field(input logic [10:0] mv, input logic osc);
		rf_level_mv <= mv;
		osc_stable <= osc;
		@(posedge pclk);
	endtask
	// One-cycle event pulse
	task automatic pulse(input nfctw_evt_t e);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
		@(posedge pclk);
	endtask
	// First frame: start of frame, decoded command, end of frame
	task automatic send_cmd(input nfctw_cmd_kind_t k,
		input nfctw_coding_t c, input logic [1:0] r);
		evt <= 9'h040;
		@(posedge pclk);
		evt <= '0;
		first_cmd_valid <= 1'h1;
		first_cmd <= '{k, c, r};
		@(posedge pclk);
		first_cmd_valid <= 1'h0;
		first_cmd <= ~first_cmd; // Stale command bits do not linger
		evt <= 9'h020;
		@(posedge pclk);
		evt <= '0;
		@(posedge pclk);
	endtask
endmodule

// ### nfc_target_wakeup_protocol_detect_tb_top.sv
// Bench of the target block: first-command rows, then resets,
// register access and status events. Uses the RF peer model.
`timescale 1ns/100ps
module nfc_target_wakeup_protocol_detect_tb_top import nfctw_pkg::*;;
	// ==========================================================
	// Signals
	typedef struct {nfctw_cmd_kind_t k; nfctw_coding_t c; logic [1:0] r;
		logic emu; nfctw_mode_t m; logic [7:0] info; logic fifo;} nfctw_row_t;
	nfctw_row_t rows [6] = '{
		'{CMD_SENS_ALL, CODE_A, RATE_106, 1'h0, MODE_PASSIVE_TARGET_SLOW_FLAG, 8'hc9, 1'h1},
		'{CMD_SENS_ALL, CODE_A, RATE_106, 1'h1, MODE_CARD_A, 8'hc9, 1'h1},
		'{CMD_SENSF, CODE_F, RATE_212, 1'h0, MODE_PAS_F, 8'hd2, 1'h0},
		'{CMD_SENSF, CODE_F, RATE_424, 1'h0, MODE_PAS_F, 8'hd3, 1'h0},
		'{CMD_ATR, CODE_A, RATE_424, 1'h0, MODE_ACTIVE, 8'hc3, 1'h0},
		'{CMD_OTHER, CODE_B, RATE_106, 1'h1, MODE_CARD_B, 8'hc5, 1'h0}};
	logic [15:0] regs [7] = '{16'h0400, 16'h1c0e, 16'h3000, 16'h3c00,
		16'h4000, 16'h60ef, 16'h6400};
	logic pclk = 1'h0;
	logic presetn, aon_por_n, psel, penable, pwrite, pready, pslverr, err;
	logic power_up_pin, supply_keep_pin, forced_power_up, supply_on, irq;
	logic osc_stable, first_cmd_valid, clock_extractor_en;
	logic fifo_cmd_write, sdd_auto_start;
	logic [1:0] sdd_id_size;
	logic [3:0] pstrb;
	logic [7:0] paddr;
	logic [10:0] rf_level_mv;
	logic [31:0] pwdata, prdata, rd;
	nfctw_first_cmd_t first_cmd;
	nfctw_evt_t evt;
	nfctw_mode_t target_mode;
	int mismatches = 0;
	int tests_run = 0;
	int fifo_cnt = 0;
	int n0;
	// ==========================================================
	// Design, RF peer and clock
	nfctw_target_top #(.BIT_CYC(8), .UNIT_CYC(4)) i_dut (.*);
	nfctw_rf_peer i_peer (.*);
	always #5 pclk = ~pclk;
	// Counts command pulses towards the FIFO
	always @(posedge pclk) if (fifo_cmd_write === 1'h1) fifo_cnt <= fifo_cnt + 1;
	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, logic [7:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n == 50) begin
			mismatches++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'h1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		if (irq !== 1'h1) begin
			mismatches++;
			wrap_up();
		end
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		{presetn, aon_por_n, psel, penable, pwrite} = 5'h00;
		{power_up_pin, supply_keep_pin} = 2'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		aon_por_n <= 1'h1;
		@(posedge pclk);
		apb(1'h1, 8'h60, 8'h01);
		apb(1'h1, 8'h58, 8'h07);
		i_peer.field(11'h1d6, 1'h1);
		repeat (5) @(posedge pclk);
		chk("below level", 32'h0, {31'h0, forced_power_up});
		i_peer.field(11'h000, 1'h0);
		foreach (rows[i]) begin
			apb(1'h1, 8'h04, {5'h0, rows[i].emu, 2'h0});
			i_peer.field(11'h1f4, 1'h1);
			wait_irq();
			chk("forced", 32'h1, {31'h0, forced_power_up});
			apb(1'h0, 8'h30, 8'h00);
			chk("status wake", 32'h04, rd);
			apb(1'h0, 8'h3c, 8'h00);
			chk("osc ok", 32'h40, rd);
			power_up_pin <= 1'h1;
			n0 = fifo_cnt;
			i_peer.send_cmd(rows[i].k, rows[i].c, rows[i].r);
			wait_irq();
			chk("mode", 32'(rows[i].m), 32'(target_mode));
			chk("extractor", {31'h0, (rows[i].m inside {MODE_PASSIVE_TARGET_SLOW_FLAG,
				MODE_CARD_A})}, {31'h0, clock_extractor_en});
			chk("fifo cmd", {31'h0, rows[i].fifo}, {31'h0, fifo_cnt != n0});
			apb(1'h0, 8'h64, 8'h00);
			chk("info", {24'h0, rows[i].info}, rd);
			apb(1'h0, 8'h64, 8'h00);
			chk("info read clr", 32'hc0, rd);
			apb(1'h0, 8'h30, 8'h00);
			chk("status rx", 32'h40, rd);
			i_peer.field(11'h000, 1'h0);
			wait_irq();
			chk("mode lost", 32'(MODE_IDLE), 32'(target_mode));
			apb(1'h0, 8'h30, 8'h00);
			chk("status lost", 32'h04, rd);
			power_up_pin <= 1'h0;
			@(posedge pclk);
			$display("row %0d done", i);
		end
		apb(1'h1, 8'h60, 8'hff);
		presetn <= 1'h0;
		@(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		foreach (regs[i]) begin
			apb(1'h0, regs[i][15:8], 8'h00);
			chk("reset val", {24'h0, regs[i][7:0]}, rd);
		end
		aon_por_n <= 1'h0;
		@(posedge pclk);
		aon_por_n <= 1'h1;
		apb(1'h0, 8'h60, 8'h00);
		chk("thr aon", 32'h0, rd);
		supply_keep_pin <= 1'h1;
		pstrb <= 4'h0;
		apb(1'h1, 8'h60, 8'h20);
		chk("keep supply", 32'h1, {31'h0, supply_on});
		pstrb <= 4'hf;
		apb(1'h0, 8'h60, 8'h00);
		chk("strobe off", 32'h0, rd);
		apb(1'h1, 8'h08, 8'h5a);
		apb(1'h0, 8'h08, 8'h00);
		chk("unmapped", 32'h1, {rd[30:0], err});
		$display("reset test done");
		power_up_pin <= 1'h1;
		apb(1'h1, 8'h04, 8'h80);
		i_peer.pulse(9'h100);
		repeat (3) @(posedge pclk);
		chk("irq tx start", 32'h0, {31'h0, irq});
		i_peer.pulse(9'h080);
		wait_irq();
		apb(1'h0, 8'h30, 8'h00);
		chk("status tx", 32'h80, rd);
		i_peer.pulse(9'h00c);
		wait_irq();
		apb(1'h0, 8'h30, 8'h00);
		chk("crc off", 32'h08, rd);
		i_peer.pulse(9'h002);
		wait_irq();
		apb(1'h1, 8'h04, 8'h00);
		chk("irq ctrl wr", 32'h0, {31'h0, irq});
		apb(1'h0, 8'h30, 8'h00);
		chk("status ctrl wr", 32'h0, rd);
		i_peer.pulse(9'h00e);
		wait_irq();
		apb(1'h0, 8'h30, 8'h00);
		chk("errors", 32'h1c, rd);
		$display("event test done");
		wrap_up();
	end
endmodule
